// *** rtl/indexed_exec_pkg.sv ***
// Behaviour
// - A decoded indexed bit-set word (upper nibble 1000, bit field bbb0) sets bit b of the byte at frame pointer plus k.
// - The indexed bit-set takes an offset of 0 to 95 and a bit index of 0 to 7 from its three-bit field.
// - A decoded indexed fill word (upper bits 0110 1000) writes FFh into the byte at frame pointer plus k, k from 0 to 95.
// - The extended-set enable defaults to 0; while it is 0 no operand is a frame-pointer offset, but bit-set and fill words still run with normal addressing.
// - With the extended set on and the access bit clear, a file operand at or below 5Fh is a frame-pointer offset and a larger one addresses memory normally.
// - In indexed operation the access-bank select bit is taken as zero and the bank select plays no part in the address.
package indexed_exec_pkg;

	// ----------------------------------------------------------------
	// Widths and field positions
	// ----------------------------------------------------------------
	localparam int ADDR_W = 12;
	localparam int DATA_W = 8;
	localparam int INSTR_W = 16;
	localparam int ACCESS_BIT = 8;
	localparam int BIT_LSB = 9;
	localparam int BIT_MSB = 11;
	localparam int FILE_MSB = 7;

	// ----------------------------------------------------------------
	// Opcodes and values
	// ----------------------------------------------------------------
	localparam logic [3:0] BITSET_OPC = 4'h8;
	localparam logic [6:0] FILL_OPC = 7'h34;
	localparam logic [7:0] OFFSET_MAX = 8'h5f;
	localparam logic [7:0] FILL_VALUE = 8'hff;
	localparam logic [7:0] ACCESS_SPLIT = 8'h80;
	localparam logic [3:0] SFR_BANK = 4'hf;
	localparam logic EXT_RESET = 1'h0;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [4:0] {
		IDLE = 5'h01,
		DECODE = 5'h02,
		READ = 5'h04,
		PROCESS = 5'h08,
		WRITE = 5'h10
	} phase_e;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic rdEn;
		logic wrEn;
		logic [DATA_W-1:0] wrData;
	} memReq_s;

	typedef struct packed {
		phase_e phase;
		logic [INSTR_W-1:0] instr;
		logic extEn;
		logic isFill;
		logic handled;
		logic indexed;
		logic ready;
		logic done;
		memReq_s mem;
	} exec_s;

	localparam exec_s RESET_STATE = '{
		phase: IDLE,
		instr: 16'h0000,
		extEn: EXT_RESET,
		isFill: 1'h0,
		handled: 1'h0,
		indexed: 1'h0,
		ready: 1'h1,
		done: 1'h0,
		mem: '{addr: 12'h000, rdEn: 1'h0, wrEn: 1'h0, wrData: 8'h00}
	};

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [DATA_W-1:0] bitMask(input logic [2:0] idx);
		bitMask = 8'h01 << idx;
	endfunction : bitMask

endpackage : indexed_exec_pkg

// *** rtl/operand_address_former.sv ***
`timescale 1ns/1ns
module operand_address_former (
	// Mode
	input wire logic extEnable,
	input wire logic accessSel,
	// Operand sources
	input wire logic [7:0] fileOperand,
	input wire logic [indexed_exec_pkg::ADDR_W-1:0] framePtr,
	input wire logic [3:0] bankSel,
	// Result
	output logic [indexed_exec_pkg::ADDR_W-1:0] effAddr,
	output logic indexed
);

	always_comb begin
		indexed = extEnable && !accessSel && (fileOperand <= indexed_exec_pkg::OFFSET_MAX);
		if (indexed) begin
			// Offset from the frame pointer, access bank taken as zero
			effAddr = indexed_exec_pkg::ADDR_W'(framePtr + {4'h0, fileOperand});
		end else if (accessSel) begin
			effAddr = {bankSel, fileOperand};
		end else if (fileOperand >= indexed_exec_pkg::ACCESS_SPLIT) begin
			effAddr = {indexed_exec_pkg::SFR_BANK, fileOperand};
		end else begin
			effAddr = {4'h0, fileOperand};
		end
	end

endmodule : operand_address_former

// *** rtl/indexed_offset_bit_set_exec.sv ***
`timescale 1ns/1ns
module indexed_offset_bit_set_exec (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	input wire logic clkEn,
	// Configuration
	input wire logic extendedSetEnable,
	// Instruction from fetch
	input wire logic instrValid,
	input wire logic [indexed_exec_pkg::INSTR_W-1:0] instrWord,
	output logic instrReady,
	// Core address state
	input wire logic [indexed_exec_pkg::ADDR_W-1:0] framePtr,
	input wire logic [3:0] bankSel,
	// Data memory
	input wire logic [indexed_exec_pkg::DATA_W-1:0] memRdData,
	output indexed_exec_pkg::memReq_s memReq,
	// Completion
	output logic done,
	output logic handled,
	output logic indexedMode
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	indexed_exec_pkg::exec_s s_q;
	indexed_exec_pkg::exec_s s_d;
	logic [indexed_exec_pkg::ADDR_W-1:0] effAddr;
	logic effIndexed;
	logic isBitSet;
	logic isFill;

	operand_address_former addrFormer (
		.extEnable(s_q.extEn),
		.accessSel(s_q.instr[indexed_exec_pkg::ACCESS_BIT]),
		.fileOperand(s_q.instr[indexed_exec_pkg::FILE_MSB:0]),
		.framePtr(framePtr),
		.bankSel(bankSel),
		.effAddr(effAddr),
		.indexed(effIndexed)
	);

	// ----------------------------------------------------------------
	// Decode
	// ----------------------------------------------------------------
	always_comb begin
		isBitSet = (s_q.instr[15:12] == indexed_exec_pkg::BITSET_OPC);
		isFill = (s_q.instr[15:9] == indexed_exec_pkg::FILL_OPC);
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		s_d = s_q;
		s_d.done = 1'h0;
		s_d.mem.rdEn = 1'h0;
		s_d.mem.wrEn = 1'h0;
		unique case (s_q.phase)
			indexed_exec_pkg::IDLE: begin
				// Enable tracks configuration only between instructions
				s_d.extEn = extendedSetEnable;
				if (instrValid && s_q.ready) begin
					s_d.instr = instrWord;
					s_d.ready = 1'h0;
					s_d.phase = indexed_exec_pkg::DECODE;
				end
			end
			indexed_exec_pkg::DECODE: begin
				s_d.handled = isBitSet || isFill;
				s_d.isFill = isFill;
				s_d.indexed = effIndexed;
				s_d.mem.addr = effAddr;
				s_d.mem.rdEn = isBitSet;
				s_d.phase = indexed_exec_pkg::READ;
			end
			indexed_exec_pkg::READ: begin
				s_d.phase = indexed_exec_pkg::PROCESS;
			end
			indexed_exec_pkg::PROCESS: begin
				if (s_q.isFill) begin
					s_d.mem.wrData = indexed_exec_pkg::FILL_VALUE;
				end else begin
					s_d.mem.wrData = memRdData | indexed_exec_pkg::bitMask(
						s_q.instr[indexed_exec_pkg::BIT_MSB:indexed_exec_pkg::BIT_LSB]);
				end
				s_d.mem.wrEn = s_q.handled;
				s_d.phase = indexed_exec_pkg::WRITE;
			end
			indexed_exec_pkg::WRITE: begin
				s_d.done = 1'h1;
				s_d.ready = 1'h1;
				s_d.phase = indexed_exec_pkg::IDLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			s_q <= indexed_exec_pkg::RESET_STATE;
		end else if (clkEn) begin
			s_q <= s_d;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	always_comb begin
		instrReady = s_q.ready;
		memReq = s_q.mem;
		done = s_q.done;
		handled = s_q.handled;
		indexedMode = s_q.indexed;
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	AST_BITSET_DATA: assert property (@(posedge clk) disable iff (reset || !clkEn)
		(s_q.phase == indexed_exec_pkg::PROCESS && s_q.handled && !s_q.isFill)
		|=> memReq.wrEn && memReq.wrData ==
			($past(memRdData) | indexed_exec_pkg::bitMask(s_q.instr[11:9])))
		else $error("bit set wrote wrong data");

	AST_ONE_BIT_ONLY: assert property (@(posedge clk) disable iff (reset || !clkEn)
		(memReq.wrEn && !s_q.isFill)
		|-> $onehot0(memReq.wrData & ~$past(memRdData)))
		else $error("bit set changed more than one bit");

	AST_FILL_VALUE: assert property (@(posedge clk) disable iff (reset || !clkEn)
		(memReq.wrEn && s_q.isFill) |-> memReq.wrData == 8'hff && !$past(memReq.rdEn, 2))
		else $error("fill did not write all ones");

	AST_EXT_DEFAULT: assert property (@(posedge clk) disable iff (reset)
		$past(reset) |-> !s_q.extEn && !indexedMode)
		else $error("extended set enabled after reset");

	AST_INDEXED_ADDR: assert property (@(posedge clk) disable iff (reset || !clkEn)
		(s_q.phase == indexed_exec_pkg::DECODE && s_q.extEn && !s_q.instr[8] &&
			s_q.instr[7:0] <= 8'h5f)
		|=> indexedMode && memReq.addr == 12'($past(framePtr) + {4'h0, s_q.instr[7:0]}))
		else $error("indexed address not frame pointer plus offset");

	AST_DIRECT_ADDR: assert property (@(posedge clk) disable iff (reset || !clkEn)
		(s_q.phase == indexed_exec_pkg::DECODE && (!s_q.extEn || s_q.instr[7:0] > 8'h5f))
		|=> !indexedMode && memReq.addr[7:0] == s_q.instr[7:0])
		else $error("operand above offset range was treated as offset");

	AST_BANK_IGNORED: assert property (@(posedge clk) disable iff (reset || !clkEn)
		(s_q.phase == indexed_exec_pkg::DECODE && s_q.extEn && !s_q.instr[8] &&
			s_q.instr[7:0] <= 8'h5f && $changed(bankSel))
		|=> memReq.addr == 12'($past(framePtr) + {4'h0, s_q.instr[7:0]}))
		else $error("bank select leaked into indexed address");

	AST_PHASE_TIMING: assert property (@(posedge clk) disable iff (reset || !clkEn)
		(instrValid && instrReady && instrWord[15:12] == 4'h8)
		|=> !instrReady ##1 memReq.rdEn ##2 memReq.wrEn ##1 (done && instrReady))
		else $error("bit set did not follow decode read process write");

	AST_WRITE_ONCE: assert property (@(posedge clk) disable iff (reset || !clkEn)
		memReq.wrEn |=> !memReq.wrEn && done && $stable(memReq.addr))
		else $error("write not single or not followed by completion");

	// ----------------------------------------------------------------
	// Assertions on sequencing and freeze
	// ----------------------------------------------------------------
	AST_RESET_IDLE: assert property (@(posedge clk)
		reset |=> s_q.phase == indexed_exec_pkg::IDLE && instrReady && !done &&
			!memReq.rdEn && !memReq.wrEn)
		else $error("reset did not return the block to idle");

	AST_READY_MATCH: assert property (@(posedge clk) disable iff (reset)
		instrReady == (s_q.phase == indexed_exec_pkg::IDLE))
		else $error("ready does not match idle phase");

	AST_DONE_PULSE: assert property (@(posedge clk) disable iff (reset || !clkEn)
		done |=> !done)
		else $error("completion lasted more than one cycle");

	AST_INSTR_HELD: assert property (@(posedge clk) disable iff (reset)
		(s_q.phase != indexed_exec_pkg::IDLE) |=> $stable(s_q.instr))
		else $error("instruction changed while in flight");

	AST_ADDR_HELD: assert property (@(posedge clk) disable iff (reset)
		(s_q.phase == indexed_exec_pkg::READ || s_q.phase == indexed_exec_pkg::PROCESS)
		|=> $stable(memReq.addr))
		else $error("data address moved between read and write");

	AST_FILL_TIMING: assert property (@(posedge clk) disable iff (reset || !clkEn)
		(instrValid && instrReady && instrWord[15:9] == indexed_exec_pkg::FILL_OPC)
		|=> !instrReady ##1 !memReq.rdEn ##2 memReq.wrEn ##1 (done && instrReady))
		else $error("fill did not follow decode read process write");

	AST_FILL_NO_READ: assert property (@(posedge clk) disable iff (reset || !clkEn)
		(s_q.phase == indexed_exec_pkg::DECODE && isFill)
		|=> handled && !memReq.rdEn)
		else $error("fill read memory or was not handled");

	AST_FOREIGN_NOP: assert property (@(posedge clk) disable iff (reset || !clkEn)
		(s_q.phase == indexed_exec_pkg::DECODE && !isBitSet && !isFill)
		|=> !handled && !memReq.rdEn ##2 !memReq.wrEn)
		else $error("other instruction touched data memory");

	AST_EXT_HELD: assert property (@(posedge clk) disable iff (reset)
		(s_q.phase != indexed_exec_pkg::IDLE) |=> $stable(s_q.extEn))
		else $error("extended set enable changed mid instruction");

	AST_EXT_LATCH: assert property (@(posedge clk) disable iff (reset || !clkEn)
		(s_q.phase == indexed_exec_pkg::IDLE)
		|=> s_q.extEn == $past(extendedSetEnable))
		else $error("extended set enable not taken while idle");

	AST_FROZEN_HOLD: assert property (@(posedge clk) disable iff (reset)
		!clkEn |=> $stable(s_q))
		else $error("state moved while clock enable was low");

	AST_NO_RD_WR: assert property (@(posedge clk) disable iff (reset)
		!(memReq.rdEn && memReq.wrEn))
		else $error("read and write requested together");

endmodule : indexed_offset_bit_set_exec

// *** dv/data_mem_model.sv ***
`timescale 1ns/1ns
module data_mem_model (
	// Clock
	input wire logic clk,
	// Request from the core
	input indexed_exec_pkg::memReq_s memReq,
	// Read answer
	output logic [7:0] memRdData
);
	logic [7:0] store [0:4095];

	// ----------------------------------------------------------------
	// Answer one cycle after a read, scramble the bus otherwise
	// ----------------------------------------------------------------
	initial memRdData = 8'h00;
	always @(posedge clk) begin
		if (memReq.rdEn === 1'b1) begin
			memRdData <= store[memReq.addr];
		end else begin
			memRdData <= ~memRdData;
		end
		if (memReq.wrEn === 1'b1) begin
			store[memReq.addr] <= memReq.wrData;
		end
	end
endmodule : data_mem_model

// *** dv/tb_top.sv ***
`timescale 1ns/1ns
module tb_top;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic clkEn = 1'b1;
	logic extOn = 1'b0;
	logic instrValid = 1'b0;
	logic [15:0] instrWord = 16'h0000;
	logic [11:0] framePtr = 12'h000;
	logic [3:0] bankSel = 4'h3;
	logic instrReady, done, handled, indexedMode;
	logic [7:0] memRdData;
	indexed_exec_pkg::memReq_s memReq;
	int fails = 0;
	int comparisons = 0;

	always #4 clk = ~clk;

	indexed_offset_bit_set_exec dut (.clk(clk), .reset(reset), .clkEn(clkEn),
		.extendedSetEnable(extOn), .instrValid(instrValid), .instrWord(instrWord),
		.instrReady(instrReady), .framePtr(framePtr), .bankSel(bankSel),
		.memRdData(memRdData), .memReq(memReq), .done(done), .handled(handled),
		.indexedMode(indexedMode));
	data_mem_model mem (.clk(clk), .memReq(memReq), .memRdData(memRdData));

	task automatic chk(input logic [11:0] got, input logic [11:0] exp);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic give_verdict();
		$display("mismatches %0d comparisons %0d", fails, comparisons);
		if (fails == 0 && comparisons > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : give_verdict

	// ----------------------------------------------------------------
	// One instruction: preload, issue, time the answer, check memory
	// ----------------------------------------------------------------
	task automatic issue(input logic [15:0] w, input int hold, input logic idx, output int n);
		@(negedge clk);
		instrWord = w;
		instrValid = 1'b1;
		@(posedge clk);
		@(negedge clk);
		instrValid = 1'b0;
		// Bank select moves while an indexed operand is formed
		if (idx) begin
			bankSel = ~bankSel;
		end
		if (hold > 0) begin
			clkEn = 1'b0;
			repeat (hold) @(negedge clk);
			clkEn = 1'b1;
		end
		n = 1 + hold;
		while (done !== 1'b1 && n < 20) begin
			@(negedge clk);
			n++;
		end
		if (idx) begin
			bankSel = ~bankSel;
		end
	endtask : issue

	task automatic exec(input logic [15:0] w, input logic [11:0] a, input logic [7:0] pre,
		input logic [7:0] exp, input logic idx);
		int n;
		mem.store[a] = pre;
		issue(w, 0, idx, n);
		chk(12'(n), 12'h005);
		chk({11'h000, handled}, 12'h001);
		chk({11'h000, indexedMode}, {11'h000, idx});
		chk({4'h0, mem.store[a]}, {4'h0, exp});
	endtask : exec

	task automatic bit_set_sweep();
		logic [7:0] k;
		for (int b = 0; b < 8; b++) begin
			k = (b == 7) ? 8'h5f : 8'(b * 13);
			exec({4'h8, 3'(b), 1'b0, k}, framePtr + {4'h0, k}, 8'h00,
				8'h01 << b, 1'b1);
		end
		exec(16'h8e0a, 12'ha0a, 8'h55, 8'hd5, 1'b1);
	endtask : bit_set_sweep

	task automatic fill_cases();
		exec(16'h682c, 12'ha2c, 8'h00, 8'hff, 1'b1);
		exec(16'h685f, 12'ha5f, 8'h12, 8'hff, 1'b1);
	endtask : fill_cases

	task automatic foreign_word();
		int n;
		mem.store[12'ha0a] = 8'h3c;
		issue(16'h2a0a, 0, 1'b1, n);
		chk(12'(n), 12'h005);
		chk({11'h000, handled}, 12'h000);
		chk({4'h0, mem.store[12'ha0a]}, 12'h03c);
	endtask : foreign_word

	task automatic frozen_bit_set();
		int n;
		mem.store[12'ha21] = 8'h40;
		issue(16'h8221, 3, 1'b1, n);
		chk(12'(n), 12'h008);
		chk({4'h0, mem.store[12'ha21]}, 12'h042);
	endtask : frozen_bit_set

	task automatic plain_addressing();
		exec(16'h8e60, 12'h060, 8'h01, 8'h81, 1'b0);
		exec(16'h8f2c, 12'h32c, 8'h10, 8'h90, 1'b0);
		@(negedge clk);
		extOn = 1'b0;
		exec(16'h8e0a, 12'h00a, 8'h02, 8'h82, 1'b0);
		exec(16'h8f0a, 12'h30a, 8'h04, 8'h84, 1'b0);
	endtask : plain_addressing

	initial begin
		#40000;
		fails++;
		give_verdict();
	end

	initial begin
		repeat (16) @(negedge clk);
		reset = 1'b0;
		chk({9'h000, instrReady, done, handled}, 12'h004);
		chk({11'h000, indexedMode}, 12'h000);
		framePtr = 12'ha00;
		extOn = 1'b1;
		bit_set_sweep();
		fill_cases();
		foreign_word();
		frozen_bit_set();
		plain_addressing();
		give_verdict();
	end
endmodule : tb_top
